// ### include/pixel_resample_consts.vh
`ifndef PIXEL_RESAMPLE_CONSTS_VH
`define PIXEL_RESAMPLE_CONSTS_VH

// Register byte addresses
`define ADDR_W           8
`define ADDR_SETUP1      8'h00
`define ADDR_SETUP2      8'h04
`define ADDR_WIN_X       8'h08
`define ADDR_WIN_Y       8'h0c
`define ADDR_STATUS      8'h10

// First setup register fields
`define S1_HALF_WIDTH    0
`define S1_HALF_HEIGHT   1
`define S1_CLOCK_RATIO   2
`define S1_SMOOTHING     3
`define S1_EXPAND        4
`define S1_W             5
`define S1_RESET         5'h00

// Second setup register fields
`define S2_STUDIO        0
`define S2_TWOS          1
`define S2_CHROMA        2
`define S2_FMT_LO        4
`define S2_FMT_HI        6
`define S2_W             7
`define S2_RESET         7'h04

// Window fields: start in low half, inclusive end in high half
`define WIN_RESET        32'hffff_0000

// Image formats
`define FMT_422          3'h0
`define FMT_411_ROW      3'h1
`define FMT_411_BLK      3'h2
`define FMT_444          3'h3
`define FMT_4444         3'h4
`define FMT_400          3'h5

// Studio range limits, chroma held in offset binary
`define LUMA_MIN         8'h10
`define LUMA_MAX         8'heb
`define CHROMA_MAX       8'hf0
`define SIGN_FLIP        8'h80

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ### rtl/pixel_resample_format_path.v
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "pixel_resample_consts.vh"
// Operation
// - Studio range clamps luma and chroma results
// - Chroma offset binary or two's complement
// - Count only pixel-enabled cycles
// - Setup bits select half sizes, ratio
// - Row-quad and mono smooth luma only
// - Block-quad format stays full size
// - Smoothing only when enable bit set
// - Three-tap compress, average expand, edge copy
// - Drop alternate lines, duplicate on expansion
// - Decimate window pixels before strip write
// - Interpolate after fetch, refetch each line once
// - Expansion window in interpolated coordinates
// - Codec side runs at system rate
// - Ratio bit applies only half-width
// - Strip access half rate, ratio status
// - Pixel side freezes, codec side runs
module pixel_resample_format_path
(
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire [`ADDR_W-1:0]   s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`ADDR_W-1:0]   s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  input  wire                 pixel_clock,
  input  wire                 line_sync_in,
  input  wire                 frame_sync_in,
  input  wire                 pixel_gate_n,
  input  wire [23:0]          pixel_in,
  output reg                  strip_wr_valid,
  output reg  [23:0]          strip_wr_data,
  input  wire                 exp_valid,
  input  wire                 exp_last,
  input  wire [23:0]          exp_data,
  output reg                  exp_ready,
  output reg                  line_refetch,
  output reg                  pix_out_valid,
  output reg  [23:0]          pix_out_data,
  output reg                  pixel_rate_full
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_INTERP = 3'h1;
  localparam ST_INT_LS = 3'h2;
  localparam ST_TAIL   = 3'h3;
  localparam ST_COPY   = 3'h4;

  reg  [`S1_W-1:0] setup1_reg;
  reg  [`S2_W-1:0] setup2_reg;
  reg  [31:0]      win_x_reg;
  reg  [31:0]      win_y_reg;
  reg  [`ADDR_W-1:0] awaddr_reg;
  reg  [31:0]      wdata_reg;
  reg              aw_held_reg;
  reg              w_held_reg;
  reg  [2:0]       pclk_sync_reg;
  reg  [1:0]       lsync_sync_reg;
  reg  [1:0]       fsync_sync_reg;
  reg  [1:0]       gate_sync_reg;
  reg  [23:0]      pix_s1_reg;
  reg  [23:0]      pix_s2_reg;
  reg              lsync_last_reg;
  reg  [15:0]      x_reg;
  reg  [15:0]      y_reg;
  reg              parity_reg;
  reg              line_hit_reg;
  reg  [23:0]      prev_reg;
  reg  [23:0]      cur_reg;
  reg              cur_valid_reg;
  reg              cur_even_reg;
  reg              pend_valid_reg;
  reg  [23:0]      pend_data_reg;
  reg              strip_phase_reg;
  reg  [2:0]       exp_state_reg;
  reg  [23:0]      hold_reg;
  reg              hold_valid_reg;
  reg  [23:0]      ia_reg;
  reg  [23:0]      ib_reg;
  reg  [15:0]      ex_reg;
  reg  [15:0]      ey_reg;
  reg              exp_parity_reg;

  wire [`ADDR_W-1:0] wr_addr = s_axi_awvalid && !aw_held_reg ? s_axi_awaddr : awaddr_reg;
  wire [31:0]      wr_data = s_axi_wvalid && !w_held_reg ? s_axi_wdata : wdata_reg;
  wire             aw_ok   = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  wire             w_ok    = w_held_reg || (s_axi_wvalid && s_axi_wready);
  wire             wr_go   = aw_ok && w_ok && !s_axi_bvalid;
  wire [2:0]       fmt     = setup2_reg[`S2_FMT_HI:`S2_FMT_LO];
  wire             blk_quad = (fmt == `FMT_411_BLK);
  wire             luma_only = (fmt == `FMT_411_ROW) || (fmt == `FMT_400);
  wire             half_w  = setup1_reg[`S1_HALF_WIDTH] && !blk_quad;
  wire             half_h  = setup1_reg[`S1_HALF_HEIGHT] && !blk_quad;
  wire             expand  = setup1_reg[`S1_EXPAND];
  wire             smooth  = setup1_reg[`S1_SMOOTHING] && half_w;
  // Pixel side only advances on enabled pixel clock edges; codec side is free running
  wire             eff     = pclk_sync_reg[1] && !pclk_sync_reg[2] && !gate_sync_reg[1];
  wire             lsync   = lsync_sync_reg[1];
  wire             fsync   = fsync_sync_reg[1];
  wire             line_fall = eff && lsync_last_reg && !lsync;
  wire             y_in    = (y_reg >= win_y_reg[15:0]) && (y_reg <= win_y_reg[31:16]);
  wire             x_in    = (x_reg >= win_x_reg[15:0]) && (x_reg <= win_x_reg[31:16]);
  wire             kept    = !half_h || !parity_reg;
  wire             take    = eff && fsync && lsync && x_in && y_in && kept && !expand;
  wire             flush   = !expand && cur_valid_reg && (line_fall || (eff && lsync && !x_in));
  wire [23:0]      tap_next = take ? pix_s2_reg : cur_reg;
  wire [23:0]      cmp_out;
  wire [23:0]      exp_out;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : comp
      // Chroma of luma-only formats passes unfiltered
      wire filt = smooth && (gi == 2 || !luma_only);
      smoothing_tap cmp_tap
      (
        .prev    (prev_reg[gi*8 +: 8]),
        .cur     (cur_reg[gi*8 +: 8]),
        .next    (tap_next[gi*8 +: 8]),
        .filt_en (filt),
        .expand  (1'b0),
        .result  (cmp_out[gi*8 +: 8])
      );
      smoothing_tap exp_tap
      (
        .prev    (ia_reg[gi*8 +: 8]),
        .cur     (ia_reg[gi*8 +: 8]),
        .next    (ib_reg[gi*8 +: 8]),
        .filt_en (filt),
        .expand  (1'b1),
        .result  (exp_out[gi*8 +: 8])
      );
    end
  endgenerate

  function [7:0] limit;
    input [7:0] v;
    input       chroma;
    input       studio;
    input       twos;
    reg   [7:0] c;
    begin
      c = v;
      if (studio && v < `LUMA_MIN)
        c = `LUMA_MIN;
      else if (studio && !chroma && v > `LUMA_MAX)
        c = `LUMA_MAX;
      else if (studio && chroma && v > `CHROMA_MAX)
        c = `CHROMA_MAX;
      limit = (chroma && twos) ? c ^ `SIGN_FLIP : c;
    end
  endfunction

  function [23:0] limit_px;
    input [23:0] p;
    input [`S2_W-1:0] s2;
    begin
      limit_px[7:0]   = limit(p[7:0], s2[`S2_CHROMA], s2[`S2_STUDIO], s2[`S2_TWOS]);
      limit_px[15:8]  = limit(p[15:8], s2[`S2_CHROMA], s2[`S2_STUDIO], s2[`S2_TWOS]);
      limit_px[23:16] = limit(p[23:16], 1'b0, s2[`S2_STUDIO], s2[`S2_TWOS]);
    end
  endfunction

  // Register bus
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      setup1_reg    <= `S1_RESET;
      setup2_reg    <= `S2_RESET;
      win_x_reg     <= `WIN_RESET;
      win_y_reg     <= `WIN_RESET;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !wr_go;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !wr_go;
      if (s_axi_awvalid && s_axi_awready && !wr_go)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_held_reg   <= 1'b0;
        w_held_reg    <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= `RESP_OKAY;
        case (wr_addr)
          `ADDR_SETUP1: setup1_reg <= wr_data[`S1_W-1:0];
          `ADDR_SETUP2: setup2_reg <= wr_data[`S2_W-1:0];
          `ADDR_WIN_X:  win_x_reg  <= wr_data;
          `ADDR_WIN_Y:  win_y_reg  <= wr_data;
          `ADDR_STATUS: s_axi_bresp <= `RESP_OKAY;
          default:      s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_SETUP1: s_axi_rdata <= {27'h0, setup1_reg};
          `ADDR_SETUP2: s_axi_rdata <= {25'h0, setup2_reg};
          `ADDR_WIN_X:  s_axi_rdata <= win_x_reg;
          `ADDR_WIN_Y:  s_axi_rdata <= win_y_reg;
          `ADDR_STATUS: s_axi_rdata <= {y_reg, 12'h000, exp_parity_reg, parity_reg, hold_valid_reg, pixel_rate_full};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pixel pins cross in through two flops; third pclk flop only feeds edge detection
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pclk_sync_reg  <= 3'h0;
      lsync_sync_reg <= 2'h3;
      fsync_sync_reg <= 2'h3;
      gate_sync_reg  <= 2'h3;
      pix_s1_reg     <= 24'h000000;
      pix_s2_reg     <= 24'h000000;
    end
    else
    begin
      pclk_sync_reg  <= {pclk_sync_reg[1:0], pixel_clock};
      lsync_sync_reg <= {lsync_sync_reg[0], line_sync_in};
      fsync_sync_reg <= {fsync_sync_reg[0], frame_sync_in};
      gate_sync_reg  <= {gate_sync_reg[0], pixel_gate_n};
      pix_s1_reg     <= pixel_in;
      pix_s2_reg     <= pix_s1_reg;
    end
  end

  // Compression path; timing relies on source keeping sync low intervals
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lsync_last_reg  <= 1'b1;
      x_reg           <= 16'h0000;
      y_reg           <= 16'h0000;
      parity_reg      <= 1'b0;
      line_hit_reg    <= 1'b0;
      prev_reg        <= 24'h000000;
      cur_reg         <= 24'h000000;
      cur_valid_reg   <= 1'b0;
      cur_even_reg    <= 1'b0;
      pend_valid_reg  <= 1'b0;
      pend_data_reg   <= 24'h000000;
      strip_phase_reg <= 1'b0;
      strip_wr_valid  <= 1'b0;
      strip_wr_data   <= 24'h000000;
      pixel_rate_full <= 1'b0;
    end
    else
    begin
      pixel_rate_full <= half_w && setup1_reg[`S1_CLOCK_RATIO];
      strip_phase_reg <= !strip_phase_reg;
      strip_wr_valid  <= 1'b0;
      // Strip buffer is only written on every other system clock
      if (pend_valid_reg && strip_phase_reg)
      begin
        strip_wr_valid <= 1'b1;
        strip_wr_data  <= limit_px(pend_data_reg, setup2_reg);
        pend_valid_reg <= 1'b0;
      end
      if (eff)
        lsync_last_reg <= lsync;
      if (eff && !fsync)
      begin
        x_reg        <= 16'h0000;
        y_reg        <= 16'h0000;
        parity_reg   <= 1'b0;
        line_hit_reg <= 1'b0;
      end
      else if (line_fall)
      begin
        x_reg        <= 16'h0000;
        y_reg        <= y_reg + 16'h0001;
        line_hit_reg <= 1'b0;
        if (line_hit_reg)
          parity_reg <= !parity_reg;
      end
      else if (eff && lsync)
      begin
        x_reg <= x_reg + 16'h0001;
        if (fsync && x_in && y_in)
          line_hit_reg <= 1'b1;
      end
      if (flush)
      begin
        cur_valid_reg <= 1'b0;
        if (cur_even_reg)
        begin
          pend_valid_reg <= 1'b1;
          pend_data_reg  <= cmp_out;
        end
      end
      else if (take && !half_w)
      begin
        pend_valid_reg <= 1'b1;
        pend_data_reg  <= pix_s2_reg;
      end
      else if (take)
      begin
        if (cur_valid_reg && cur_even_reg)
        begin
          pend_valid_reg <= 1'b1;
          pend_data_reg  <= cmp_out;
        end
        prev_reg      <= cur_valid_reg ? cur_reg : pix_s2_reg;
        cur_reg       <= pix_s2_reg;
        cur_valid_reg <= 1'b1;
        cur_even_reg  <= cur_valid_reg ? !cur_even_reg : 1'b1;
      end
    end
  end

  // Expansion path runs every system clock regardless of the pixel gate
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exp_state_reg  <= ST_IDLE;
      exp_ready      <= 1'b0;
      hold_reg       <= 24'h000000;
      hold_valid_reg <= 1'b0;
      ia_reg         <= 24'h000000;
      ib_reg         <= 24'h000000;
      ex_reg         <= 16'h0000;
      ey_reg         <= 16'h0000;
      exp_parity_reg <= 1'b0;
      line_refetch   <= 1'b0;
      pix_out_valid  <= 1'b0;
      pix_out_data   <= 24'h000000;
    end
    else
    begin
      line_refetch  <= 1'b0;
      pix_out_valid <= 1'b0;
      if (eff && !fsync)
      begin
        ey_reg         <= 16'h0000;
        exp_parity_reg <= 1'b0;
      end
      case (exp_state_reg)
        ST_IDLE:
        begin
          exp_ready <= expand;
          if (exp_valid && exp_ready)
          begin
            if (!half_w)
            begin
              pix_out_valid <= x_in_e(ex_reg) && y_in_e(ey_reg);
              pix_out_data  <= limit_px(exp_data, setup2_reg);
              ex_reg        <= exp_last ? 16'h0000 : ex_reg + 16'h0001;
              if (exp_last)
                end_line(1'b0);
            end
            else
            begin
              hold_reg       <= exp_data;
              hold_valid_reg <= 1'b1;
              ia_reg         <= hold_reg;
              ib_reg         <= exp_data;
              if (hold_valid_reg)
              begin
                emit(hold_reg);
                exp_state_reg <= exp_last ? ST_INT_LS : ST_INTERP;
              end
              else if (exp_last)
                exp_state_reg <= ST_TAIL;
              exp_ready <= !(hold_valid_reg || exp_last);
            end
          end
        end
        ST_INTERP:
        begin
          emit(exp_out);
          exp_state_reg <= ST_IDLE;
          exp_ready     <= 1'b1;
        end
        ST_INT_LS:
        begin
          emit(exp_out);
          exp_state_reg <= ST_TAIL;
        end
        ST_TAIL:
        begin
          emit(hold_reg);
          exp_state_reg <= ST_COPY;
        end
        ST_COPY:
        begin
          emit(hold_reg);
          hold_valid_reg <= 1'b0;
          ex_reg         <= 16'h0000;
          end_line(1'b0);
          exp_state_reg  <= ST_IDLE;
          exp_ready      <= 1'b1;
        end
        default:
          exp_state_reg <= ST_IDLE;
      endcase
    end
  end

  function x_in_e;
    input [15:0] v;
    x_in_e = (v >= win_x_reg[15:0]) && (v <= win_x_reg[31:16]);
  endfunction

  function y_in_e;
    input [15:0] v;
    y_in_e = (v >= win_y_reg[15:0]) && (v <= win_y_reg[31:16]);
  endfunction

  task emit;
    input [23:0] p;
    begin
      pix_out_valid <= x_in_e(ex_reg) && y_in_e(ey_reg);
      pix_out_data  <= limit_px(p, setup2_reg);
      ex_reg        <= ex_reg + 16'h0001;
    end
  endtask

  task end_line;
    input unused_flag;
    begin
      ey_reg <= ey_reg + 16'h0001;
      if (half_h && !exp_parity_reg)
        line_refetch <= 1'b1;
      exp_parity_reg <= half_h ? !exp_parity_reg : 1'b0;
    end
  endtask
endmodule

// ### rtl/smoothing_tap.v
`timescale 1ns/1ps
module smoothing_tap
(
  input  wire [7:0] prev,
  input  wire [7:0] cur,
  input  wire [7:0] next,
  input  wire       filt_en,
  input  wire       expand,
  output reg  [7:0] result
);
  reg [9:0] sum;
  always @*
  begin
    sum = 10'h000;
    if (!filt_en)
      result = cur;
    else if (expand)
    begin
      sum = {2'b00, prev} + {2'b00, next};
      result = sum[8:1];
    end
    else
    begin
      sum = {2'b00, prev} + {1'b0, cur, 1'b0} + {2'b00, next};
      result = sum[9:2];
    end
  end
endmodule

// ### test/pixel_resample_format_path_checker.sv
`timescale 1ns/1ps
module pixel_resample_format_path_checker
(
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        pixel_clock,
  input wire        pixel_gate_n,
  input wire        strip_wr_valid,
  input wire        exp_valid,
  input wire        exp_ready,
  input wire        line_refetch,
  input wire        pix_out_valid,
  input wire        pixel_rate_full
);
  reg       aw_got, w_got, pc_d;
  reg [3:0] eff_cnt, take_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Raw pin edge, seen earlier than the design's synchroniser sees it
  always @(posedge aclk)
  begin
    pc_d <= pixel_clock;
    eff_cnt <= (pixel_clock & ~pc_d & ~pixel_gate_n) ? 4'h0 : eff_cnt + {3'h0, eff_cnt != 4'hf};
    take_cnt <= (exp_valid & exp_ready) ? 4'h0 : take_cnt + {3'h0, take_cnt != 4'hf};
    aw_got <= aresetn & ~(s_axi_bvalid & s_axi_bready) & (aw_got | (s_axi_awvalid & s_axi_awready));
    w_got <= aresetn & ~(s_axi_bvalid & s_axi_bready) & (w_got | (s_axi_wvalid & s_axi_wready));
  end
  sequence wr_both;
    (aw_got || (s_axi_awvalid && s_axi_awready)) && (w_got || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_both |=> s_axi_bvalid) else $error("write answer late");
  a_write_order: assert property ($rose(s_axi_bvalid) |-> aw_got && w_got) else $error("early bvalid");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_strip_pulse: assert property (strip_wr_valid |=> !strip_wr_valid) else $error("strip write not halved");
  a_freeze_write: assert property (strip_wr_valid |-> eff_cnt <= 4'h8) else $error("write without pixel");
  a_refetch_pulse: assert property (line_refetch |=> !line_refetch) else $error("refetch too long");
  a_out_after_take: assert property (pix_out_valid |-> take_cnt <= 4'h6) else $error("output without fetch");
  a_rate_by_write: assert property ($changed(pixel_rate_full) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("rate moved alone");
endmodule
bind pixel_resample_format_path pixel_resample_format_path_checker chk (.*);

// ### test/pixel_resample_format_path_tb_top.sv
`timescale 1ns/1ps
`include "pixel_resample_consts.vh"
module pixel_resample_format_path_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pixel_clock, line_sync_in, frame_sync_in, pixel_gate_n, strip_wr_valid;
  logic        exp_valid, exp_last, exp_ready, line_refetch, pix_out_valid, pixel_rate_full;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] pixel_in, strip_wr_data, exp_data, pix_out_data;
  logic [23:0] sq[$], oq[$], eq[$];
  int          mismatches, compares, nref;

  pixel_resample_format_path uut (.*);
  pixel_source_model src (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(inout int n);
    n++;
    if (n > 200)
    begin
      mismatches++;
      $display("mismatch at %0t: wait timed out", $time);
      end_sim;
    end
    @(posedge aclk);
  endtask

  // Ready lines on the response channels stay high, so back-to-back calls never retoggle them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask

  task automatic xline(input logic [71:0] v);
    int n = 0;
    for (int k = 0; k < 3; k++)
    begin
      exp_valid <= 1'b1;
      exp_data <= v[71 - 24 * k -: 24];
      exp_last <= (k == 2);
      do tick(n); while (!exp_ready);
    end
    exp_valid <= 1'b0;
    exp_data <= ~v[23:0];
    exp_last <= 1'b0;
  endtask

  task automatic cmpq(input logic [23:0] q[$]);
    repeat (4) @(posedge aclk);
    chk(q.size(), eq.size());
    foreach (eq[k]) if (k < q.size()) chk(q[k], eq[k]);
    sq.delete();
    oq.delete();
    eq.delete();
  endtask

  function automatic logic [23:0] fpx(input logic [23:0] p, c, n, input logic fa);
    for (int k = 0; k < 3; k++)
      fpx[k*8+:8] = (k < 2 && !fa) ? c[k*8+:8] :
        8'(({2'h0, p[k*8+:8]} + {1'h0, c[k*8+:8], 1'h0} + {2'h0, n[k*8+:8]}) >> 2);
  endfunction

  function automatic logic [23:0] av(input logic [23:0] a, b);
    for (int k = 0; k < 3; k++)
      av[k*8+:8] = 8'(({1'h0, a[k*8+:8]} + {1'h0, b[k*8+:8]}) >> 1);
  endfunction

  function automatic logic [23:0] clp(input logic [23:0] p, input logic st, tw);
    logic [7:0] v, hi;
    for (int k = 0; k < 3; k++)
    begin
      v = p[k*8+:8];
      hi = (k == 2) ? `LUMA_MAX : `CHROMA_MAX;
      if (st && v < `LUMA_MIN) v = `LUMA_MIN;
      if (st && v > hi) v = hi;
      if (tw && k < 2) v = v ^ `SIGN_FLIP;
      clp[k*8+:8] = v;
    end
  endfunction

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (strip_wr_valid === 1'b1) sq.push_back(strip_wr_data);
    if (pix_out_valid === 1'b1) oq.push_back(pix_out_data);
    if (line_refetch === 1'b1) nref++;
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, exp_valid, exp_last} = 6'h00;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, exp_data} = 72'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADDR_SETUP1, 32'h0, `RESP_OKAY);
    rd(`ADDR_SETUP2, 32'h4, `RESP_OKAY);
    rd(`ADDR_WIN_X, `WIN_RESET, `RESP_OKAY);
    rd(8'h14, 32'h0, `RESP_SLVERR);
    wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
    wr(8'h20, 32'h1, `RESP_SLVERR);
    for (int k = 0; k < 3; k++)
    begin
      wr(`ADDR_SETUP1, (k == 1) ? 32'h5 : 32'h4 - 32'(3 * k / 2), `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(pixel_rate_full, k == 1);
    end
    $display("test registers done");
    wr(`ADDR_SETUP1, 32'h0, `RESP_OKAY);
    for (int m = 0; m < 4; m++)
    begin
      wr(`ADDR_SETUP2, 32'h4 | 32'(m), `RESP_OKAY);
      src.send_frame(1, 4, m[0]);
      for (int i = 0; i < 4; i++) eq.push_back(clp(src.pv[i], m[0], m[1]));
      cmpq(sq);
    end
    wr(`ADDR_WIN_X, 32'h0002_0001, `RESP_OKAY);
    src.send_frame(1, 4, 1'b0);
    eq = {clp(src.pv[1], 1'b1, 1'b1), clp(src.pv[2], 1'b1, 1'b1)};
    cmpq(sq);
    wr(`ADDR_WIN_X, `WIN_RESET, `RESP_OKAY);
    $display("test range done");
    for (int f = 0; f < 7; f++)
    begin
      wr(`ADDR_SETUP1, (f < 6) ? 32'h9 : 32'h1, `RESP_OKAY);
      wr(`ADDR_SETUP2, 32'h4 | 32'((f % 6) << 4), `RESP_OKAY);
      src.send_frame(1, 4, 1'b1);
      if (f == 2) for (int i = 0; i < 4; i++) eq.push_back(src.pv[i]);
      else if (f == 6) eq = '{src.pv[0], src.pv[2]};
      else eq = '{fpx(src.pv[0], src.pv[0], src.pv[1], f != 1 && f != 5),
                  fpx(src.pv[1], src.pv[2], src.pv[3], f != 1 && f != 5)};
      cmpq(sq);
    end
    $display("test decimation done");
    wr(`ADDR_SETUP1, 32'h2, `RESP_OKAY);
    wr(`ADDR_SETUP2, 32'h4, `RESP_OKAY);
    src.send_frame(3, 4, 1'b0);
    src.send_frame(1, 4, 1'b0);
    for (int i = 0; i < 12; i++) if (i < 4 || i > 7) eq.push_back(src.pv[i]);
    for (int i = 0; i < 4; i++) eq.push_back(src.pv[i]);
    cmpq(sq);
    $display("test line drop done");
    wr(`ADDR_SETUP1, 32'h1b, `RESP_OKAY);
    repeat (2)
    begin
      xline({src.pv[0], src.pv[1], src.pv[2]});
      repeat (12) @(posedge aclk);
      eq = {eq, src.pv[0], av(src.pv[0], src.pv[1]), src.pv[1],
             av(src.pv[1], src.pv[2]), src.pv[2], src.pv[2]};
    end
    cmpq(oq);
    chk(nref, 1);
    $display("test expansion done");
    end_sim;
  end
endmodule

// ### test/pixel_source_model.sv
`timescale 1ns/1ps
module pixel_source_model
(
  output logic        pixel_clock,
  output logic        line_sync_in,
  output logic        frame_sync_in,
  output logic        pixel_gate_n,
  output logic [23:0] pixel_in
);
  logic [23:0] pv [0:11];

  initial
  begin
    {pixel_clock, line_sync_in, frame_sync_in, pixel_gate_n} = 4'h7;
    pixel_in = 24'h5a5a5a;
    pv[0] = 24'h08f805;
    pv[1] = 24'hf010ff;
    pv[2] = 24'h4080c0;
    pv[3] = 24'hecf10f;
    for (int k = 4; k < 12; k++)
      pv[k] = {8'(k * 19), 8'(k * 7 + 3), 8'(255 - k)};
  end

  // Signals move only while the clock is low, so each rising edge sees them settled
  task automatic edge1(input logic g, h, v, input logic [23:0] d);
    pixel_gate_n = g;
    line_sync_in = h;
    frame_sync_in = v;
    pixel_in = d;
    #160 pixel_clock = 1'b1;
    #160 pixel_clock = 1'b0;
  endtask

  task automatic send_frame(input int nl, input int np, input logic stall);
    #7;
    repeat (2) edge1(1'b0, 1'b0, 1'b0, ~pixel_in);
    for (int l = 0; l < nl; l++)
    begin
      if (l > 0) repeat (2) edge1(1'b0, 1'b0, 1'b1, ~pixel_in);
      for (int i = 0; i < np; i++)
      begin
        if (stall) edge1(1'b1, 1'b0, 1'b0, ~pixel_in);
        edge1(1'b0, 1'b1, 1'b1, pv[l * np + i]);
      end
    end
    repeat (2) edge1(1'b0, 1'b0, 1'b1, ~pixel_in);
    pixel_in = ~pixel_in;
    pixel_gate_n = 1'b1;
  endtask
endmodule
